// ---- inc/dbg_consts.svh ----
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH

// ***********************************
// Register indices (byte address = 4 x index)
// ***********************************
`define IDX_TILE_CELL_OSC   8'h07
`define IDX_TILE_WIRE_OSC   8'h08
`define IDX_PERIPH_CELL_OSC 8'h09
`define IDX_PERIPH_WIRE_OSC 8'h0a
`define IDX_RAM_SIZE        8'h0c
`define IDX_SAVED_STATUS    8'h10
`define IDX_SAVED_PC        8'h11
`define IDX_SAVED_SP        8'h12
`define IDX_READ_THREAD     8'h13
`define IDX_READ_REGNUM     8'h14
`define IDX_IRQ_CAUSE       8'h15
`define IDX_IRQ_INFO        8'h16
`define IDX_STOP_MASK       8'h18
`define IDX_SCRATCH_FIRST   8'h20
`define IDX_SCRATCH_LAST    8'h27
`define IDX_IBRK_ADDR_FIRST 8'h30
`define IDX_IBRK_ADDR_LAST  8'h33
`define IDX_IBRK_CTRL_FIRST 8'h40
`define IDX_IBRK_CTRL_LAST  8'h43

// ***********************************
// Address decode
// ***********************************
`define ADDR_W      12
`define IDX_MSB     9
`define IDX_LSB     2
`define ADDR_TOP_ZERO 2'b00

// ***********************************
// Field layouts and values
// ***********************************
`define OSC_W          16
`define NUM_OSC        4
`define NUM_SCRATCH    8
`define NUM_IBRK       4
`define STATUS_W        11
`define STATUS_RO_BIT   8
`define STATUS_WR_MASK  11'h6df
`define STATUS_CAP_MASK 11'h7df
`define CAUSE_LSB      0
`define THREAD_LSB     8
`define UNIT_LSB       16
`define IBRK_EN_BIT    0
`define IBRK_NE_BIT    1
`define IBRK_THR_LSB   16
`define IBRK_CTRL_MASK 32'h00ff0003
`define CAUSE_NONE     3'h0
`define CAUSE_HOST     3'h1
`define CAUSE_CALL     3'h2
`define CAUSE_IBRK     3'h3
`define CAUSE_DWATCH   3'h4
`define CAUSE_RWATCH   3'h5
`define RAM_SIZE_DEFAULT 32'h00080000
`define RAM_LOW_ZERO   2'b00

`endif

// ---- inc/dbg_pkg.sv ----
package dbg_pkg;
	typedef logic [31:0] word_t;
	typedef logic [7:0]  thread_mask_t;
	typedef logic [7:0]  reg_idx_t;
	typedef logic [2:0]  cause_t;
	typedef logic [1:0]  unit_t;
endpackage : dbg_pkg

// ---- src/osc_count_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dbg_consts.svh"

// Two-flop crossing of a free-running counter. Bits may be caught mid-change
// while the oscillator runs; the value is only coherent once it is stopped.
module osc_count_sync
(
	input  wire logic                clk_sys,
	input  wire logic [`OSC_W-1:0]   count_async,
	output logic      [`OSC_W-1:0]   count
);

	logic [`OSC_W-1:0] meta;

	// No reset: the count survives a system reset
	always_ff @(posedge clk_sys)
	begin
		meta  <= count_async;
		count <= meta;
	end

endmodule : osc_count_sync
`default_nettype wire

// ---- src/ibreak_match.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dbg_consts.svh"

module ibreak_match
(
	input  wire logic                      clk_sys,
	input  wire logic                      reset,
	input  wire logic [31:0]               pc,
	input  wire logic                      pc_valid,
	input  wire logic [2:0]                pc_thread,
	input  wire logic [`NUM_IBRK-1:0][31:0] brk_addr,
	input  wire logic [`NUM_IBRK-1:0][31:0] brk_ctrl,
	output logic      [`NUM_IBRK-1:0]      hit,
	output logic                           irq
);

	logic [`NUM_IBRK-1:0] next_hit;

	genvar g;
	generate
		for (g = 0; g < `NUM_IBRK; g++)
		begin : g_unit
			logic thr_en;
			logic eq;
			assign thr_en = brk_ctrl[g][`IBRK_THR_LSB + pc_thread];
			assign eq     = (pc == brk_addr[g]);
			assign next_hit[g] = pc_valid && brk_ctrl[g][`IBRK_EN_BIT] && thr_en &&
				(brk_ctrl[g][`IBRK_NE_BIT] ? !eq : eq);
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			hit <= '0;
			irq <= 1'b0;
		end
		else
		begin
			hit <= next_hit;
			irq <= |next_hit;
		end
	end

	property p_ibrk_eq;
		@(posedge clk_sys) disable iff (reset)
		pc_valid && brk_ctrl[0][`IBRK_EN_BIT] && !brk_ctrl[0][`IBRK_NE_BIT] &&
		brk_ctrl[0][`IBRK_THR_LSB + pc_thread] && pc == brk_addr[0] |=> hit[0] && irq;
	endproperty
	a_ibrk_eq : assert property (p_ibrk_eq)
		else $error("enabled equality breakpoint did not fire");

endmodule : ibreak_match
`default_nettype wire

// ---- src/debug_status_regs.sv ----
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dbg_consts.svh"

module debug_status_regs
#(
	parameter logic [31:0] RAM_SIZE_BYTES = `RAM_SIZE_DEFAULT
)
(
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [`ADDR_W-1:0]   paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic      [31:0]          prdata,
	output logic                      pslverr,
	input  wire logic                 debug_mode,
	input  wire logic [`OSC_W-1:0]    osc_tile_cell,
	input  wire logic [`OSC_W-1:0]    osc_tile_wire,
	input  wire logic [`OSC_W-1:0]    osc_periph_cell,
	input  wire logic [`OSC_W-1:0]    osc_periph_wire,
	input  wire logic                 dbg_entry,
	input  wire logic [`STATUS_W-1:0] entry_status,
	input  wire logic [31:0]          entry_pc,
	input  wire logic [31:0]          entry_sp,
	input  wire logic [2:0]           entry_cause,
	input  wire logic [7:0]           entry_thread,
	input  wire logic [`NUM_IBRK-1:0] entry_unit_hits,
	input  wire logic [31:0]          entry_data,
	input  wire logic                 cfg_scratch_wr,
	input  wire logic [2:0]           cfg_scratch_idx,
	input  wire logic [31:0]          cfg_scratch_wdata,
	output logic      [31:0]          cfg_scratch_rdata,
	output logic      [7:0]           core_sel_thread,
	output logic      [4:0]           core_sel_reg,
	output logic      [7:0]           thread_stop,
	input  wire logic [31:0]          pc,
	input  wire logic                 pc_valid,
	input  wire logic [2:0]           pc_thread,
	output logic      [`NUM_IBRK-1:0] ibreak_hit,
	output logic                      ibreak_irq
);

	// ***********************************
	// Storage
	// ***********************************
	logic [`STATUS_W-1:0]        saved_status_word;
	dbg_pkg::word_t              saved_program_counter;
	dbg_pkg::word_t              saved_stack_pointer;
	dbg_pkg::cause_t             irq_cause;
	dbg_pkg::thread_mask_t       irq_thread;
	dbg_pkg::unit_t              irq_unit;
	dbg_pkg::word_t              irq_info;
	dbg_pkg::word_t              scratch [`NUM_SCRATCH];
	logic [`NUM_IBRK-1:0][31:0]  instr_break_target_value;
	logic [`NUM_IBRK-1:0][31:0]  ibrk_ctrl;
	logic [`NUM_OSC-1:0][`OSC_W-1:0] osc_async;
	logic [`NUM_OSC-1:0][`OSC_W-1:0] osc_count;

	dbg_pkg::reg_idx_t           idx;
	logic                        addr_ok;
	logic                        setup;
	logic                        apb_wr;
	logic                        debug_only_read_write;
	logic [31:0]                 next_prdata;
	logic                        next_pslverr;
	dbg_pkg::unit_t              next_unit;
	logic                        no_unit_cause;

	assign idx     = paddr[`IDX_MSB:`IDX_LSB];
	assign addr_ok = (paddr[`ADDR_W-1:`IDX_MSB+1] == `ADDR_TOP_ZERO) &&
		(paddr[`IDX_LSB-1:0] == `RAM_LOW_ZERO);
	assign setup   = psel && !penable;
	// Single write moment: the access edge with pready high
	assign apb_wr  = psel && penable && pready && pwrite && !pslverr;
	assign debug_only_read_write = apb_wr && debug_mode;

	// ***********************************
	// Oscillator counters
	// ***********************************
	assign osc_async = {osc_periph_wire, osc_periph_cell, osc_tile_wire, osc_tile_cell};

	genvar g;
	generate
		for (g = 0; g < `NUM_OSC; g++)
		begin : g_osc
			osc_count_sync u_sync
			(
				.clk_sys     (clk_sys),
				.count_async (osc_async[g]),
				.count       (osc_count[g])
			);
		end
	endgenerate

	// ***********************************
	// Read decode
	// ***********************************
	always_comb
	begin
		next_prdata  = '0;
		next_pslverr = 1'b0;
		case (idx) inside
			`IDX_TILE_CELL_OSC:   next_prdata[`OSC_W-1:0] = osc_count[0];
			`IDX_TILE_WIRE_OSC:   next_prdata[`OSC_W-1:0] = osc_count[1];
			`IDX_PERIPH_CELL_OSC: next_prdata[`OSC_W-1:0] = osc_count[2];
			`IDX_PERIPH_WIRE_OSC: next_prdata[`OSC_W-1:0] = osc_count[3];
			`IDX_RAM_SIZE:        next_prdata = {RAM_SIZE_BYTES[31:2], `RAM_LOW_ZERO};
			`IDX_SAVED_STATUS:    next_prdata[`STATUS_W-1:0] = saved_status_word;
			`IDX_SAVED_PC:        next_prdata = saved_program_counter;
			`IDX_SAVED_SP:        next_prdata = saved_stack_pointer;
			`IDX_READ_THREAD:     next_prdata[7:0] = core_sel_thread;
			`IDX_READ_REGNUM:     next_prdata[4:0] = core_sel_reg;
			`IDX_IRQ_CAUSE:
			begin
				next_prdata[`CAUSE_LSB +: 3]  = irq_cause;
				next_prdata[`THREAD_LSB +: 8] = irq_thread;
				next_prdata[`UNIT_LSB +: 2]   = irq_unit;
			end
			`IDX_IRQ_INFO:        next_prdata = irq_info;
			`IDX_STOP_MASK:       next_prdata[7:0] = thread_stop;
			[`IDX_SCRATCH_FIRST:`IDX_SCRATCH_LAST]:
				next_prdata = scratch[idx[2:0]];
			[`IDX_IBRK_ADDR_FIRST:`IDX_IBRK_ADDR_LAST]:
				next_prdata = instr_break_target_value[idx[1:0]];
			[`IDX_IBRK_CTRL_FIRST:`IDX_IBRK_CTRL_LAST]:
				next_prdata = ibrk_ctrl[idx[1:0]];
			default:              next_pslverr = 1'b1;
		endcase
		if (!addr_ok)
		begin
			next_prdata  = '0;
			next_pslverr = 1'b1;
		end
	end

	// ***********************************
	// APB answer: one wait-free access cycle
	// ***********************************
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			pready  <= 1'b1;
			prdata  <= pwrite ? '0 : next_prdata;
			pslverr <= next_pslverr;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ***********************************
	// Debugger-entry capture
	// ***********************************
	// Capture beats a debugger write landing in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			saved_status_word     <= '0;
			saved_program_counter <= '0;
			saved_stack_pointer   <= '0;
		end
		else if (dbg_entry)
		begin
			saved_status_word     <= entry_status & `STATUS_CAP_MASK;
			saved_program_counter <= entry_pc;
			saved_stack_pointer   <= entry_sp;
		end
		else if (debug_only_read_write)
		begin
			if (idx == `IDX_SAVED_STATUS)
				saved_status_word <= (saved_status_word & ~`STATUS_WR_MASK) |
					(pwdata[`STATUS_W-1:0] & `STATUS_WR_MASK);
			if (idx == `IDX_SAVED_PC)
				saved_program_counter <= pwdata;
			if (idx == `IDX_SAVED_SP)
				saved_stack_pointer <= pwdata;
		end
	end

	// ***********************************
	// Interrupt cause, thread, unit, data
	// ***********************************
	always_comb
	begin
		next_unit = '0;
		casez (entry_unit_hits)
			4'b???1: next_unit = 2'd0;
			4'b??10: next_unit = 2'd1;
			4'b?100: next_unit = 2'd2;
			4'b1000: next_unit = 2'd3;
			default: next_unit = 2'd0;
		endcase
	end

	assign no_unit_cause = (entry_cause == `CAUSE_HOST) || (entry_cause == `CAUSE_CALL);

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			irq_cause  <= `CAUSE_NONE;
			irq_thread <= '0;
			irq_unit   <= '0;
		end
		else if (dbg_entry)
		begin
			irq_cause  <= entry_cause;
			irq_thread <= (entry_cause == `CAUSE_HOST) ? '0 : entry_thread;
			irq_unit   <= no_unit_cause ? '0 : next_unit;
		end
		else if (debug_only_read_write && idx == `IDX_IRQ_CAUSE)
		begin
			irq_cause  <= pwdata[`CAUSE_LSB +: 3];
			irq_thread <= pwdata[`THREAD_LSB +: 8];
			irq_unit   <= pwdata[`UNIT_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			irq_info <= '0;
		else if (dbg_entry && (entry_cause == `CAUSE_DWATCH || entry_cause == `CAUSE_RWATCH))
			irq_info <= entry_data;
		else if (debug_only_read_write && idx == `IDX_IRQ_INFO)
			irq_info <= pwdata;
	end

	// ***********************************
	// Operands and stop mask
	// ***********************************
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			core_sel_thread <= '0;
			core_sel_reg    <= '0;
			thread_stop     <= '0;
		end
		else if (debug_only_read_write)
		begin
			if (idx == `IDX_READ_THREAD)
				core_sel_thread <= pwdata[7:0];
			if (idx == `IDX_READ_REGNUM)
				core_sel_reg <= pwdata[4:0];
			if (idx == `IDX_STOP_MASK)
				thread_stop <= pwdata[7:0];
		end
	end

	// ***********************************
	// Scratch, two views of one store
	// ***********************************
	// Config-space write wins over APB on the same entry in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			for (int i = 0; i < `NUM_SCRATCH; i++)
				scratch[i] <= '0;
			cfg_scratch_rdata <= '0;
		end
		else
		begin
			for (int i = 0; i < `NUM_SCRATCH; i++)
			begin
				if (cfg_scratch_wr && cfg_scratch_idx == 3'(i))
					scratch[i] <= cfg_scratch_wdata;
				else if (debug_only_read_write && idx == (`IDX_SCRATCH_FIRST | 8'(i)))
					scratch[i] <= pwdata;
			end
			cfg_scratch_rdata <= scratch[cfg_scratch_idx];
		end
	end

	// ***********************************
	// Instruction breakpoints
	// ***********************************
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			instr_break_target_value <= '0;
			ibrk_ctrl                <= '0;
		end
		else if (debug_only_read_write)
		begin
			if (idx inside {[`IDX_IBRK_ADDR_FIRST:`IDX_IBRK_ADDR_LAST]})
				instr_break_target_value[idx[1:0]] <= pwdata;
			if (idx inside {[`IDX_IBRK_CTRL_FIRST:`IDX_IBRK_CTRL_LAST]})
				ibrk_ctrl[idx[1:0]] <= pwdata & `IBRK_CTRL_MASK;
		end
	end

	ibreak_match u_ibreak
	(
		.clk_sys   (clk_sys),
		.reset     (reset),
		.pc        (pc),
		.pc_valid  (pc_valid),
		.pc_thread (pc_thread),
		.brk_addr  (instr_break_target_value),
		.brk_ctrl  (ibrk_ctrl),
		.hit       (ibreak_hit),
		.irq       (ibreak_irq)
	);

	// ***********************************
	// Assertions
	// ***********************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_rd_setup(logic [7:0] i);
		psel && !penable && !pwrite && addr_ok && idx == i;
	endsequence

	sequence s_entry(logic [2:0] c);
		dbg_entry && entry_cause == c;
	endsequence

	property p_osc_read;
		s_rd_setup(`IDX_TILE_CELL_OSC) |=> pready && prdata[31:16] == '0 &&
			prdata[15:0] == $past(osc_count[0]);
	endproperty
	a_osc_read : assert property (p_osc_read)
		else $error("oscillator count read wrong");

	property p_ram_read;
		s_rd_setup(`IDX_RAM_SIZE) |=> pready && !pslverr &&
			prdata == {RAM_SIZE_BYTES[31:2], `RAM_LOW_ZERO};
	endproperty
	a_ram_read : assert property (p_ram_read)
		else $error("RAM size read wrong");

	property p_status_ro;
		debug_only_read_write && idx == `IDX_SAVED_STATUS && !dbg_entry |=>
			saved_status_word[`STATUS_RO_BIT] == $past(saved_status_word[`STATUS_RO_BIT]);
	endproperty
	a_status_ro : assert property (p_status_ro)
		else $error("read-only status bit changed by write");

	property p_pc_capture;
		dbg_entry |=> saved_program_counter == $past(entry_pc);
	endproperty
	a_pc_capture : assert property (p_pc_capture)
		else $error("program counter not captured");

	property p_sp_capture;
		dbg_entry ##1 !dbg_entry |-> saved_stack_pointer == $past(entry_sp);
	endproperty
	a_sp_capture : assert property (p_sp_capture)
		else $error("stack pointer not captured");

	property p_host_entry;
		s_entry(`CAUSE_HOST) |=> irq_cause == `CAUSE_HOST && irq_thread == '0 &&
			irq_unit == '0;
	endproperty
	a_host_entry : assert property (p_host_entry)
		else $error("host entry fields wrong");

	property p_unit_lowest;
		s_entry(`CAUSE_IBRK) ##0 entry_unit_hits == 4'b1010 |=> irq_unit == 2'd1;
	endproperty
	a_unit_lowest : assert property (p_unit_lowest)
		else $error("lowest unit not recorded");

	property p_data_watch;
		s_entry(`CAUSE_DWATCH) |=> irq_info == $past(entry_data) &&
			irq_cause == `CAUSE_DWATCH;
	endproperty
	a_data_watch : assert property (p_data_watch)
		else $error("watch address not recorded");

	property p_stop_locked;
		apb_wr && !debug_mode && idx == `IDX_STOP_MASK |=> $stable(thread_stop);
	endproperty
	a_stop_locked : assert property (p_stop_locked)
		else $error("stop mask written outside debug mode");

	property p_scratch_view;
		debug_only_read_write && idx == `IDX_SCRATCH_FIRST && !cfg_scratch_wr &&
		cfg_scratch_idx == '0 ##1 cfg_scratch_idx == '0 && !cfg_scratch_wr |=>
			cfg_scratch_rdata == $past(pwdata, 2);
	endproperty
	a_scratch_view : assert property (p_scratch_view)
		else $error("scratch write not seen in config view");

	property p_answer_one;
		setup |=> pready ##1 !pready;
	endproperty
	a_answer_one : assert property (p_answer_one)
		else $error("APB answer not a single cycle");

endmodule : debug_status_regs
`default_nettype wire

// ---- dv/osc_ring_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ****
// Free-running oscillators, unrelated to clk_sys
// ****
module osc_ring_model
(
	input  wire logic        run,
	output logic      [15:0] cnt_tile_cell,
	output logic      [15:0] cnt_tile_wire,
	output logic      [15:0] cnt_periph_cell,
	output logic      [15:0] cnt_periph_wire
);
	initial
	begin
		cnt_tile_cell = 16'h1234;
		cnt_tile_wire = 16'h8001;
		cnt_periph_cell = 16'hfff0;
		cnt_periph_wire = 16'h0042;
		// Steps differ so a swapped register shows up
		forever
		begin
			#3.7;
			if (run)
			begin
				cnt_tile_cell = cnt_tile_cell + 16'h0001;
				cnt_tile_wire = cnt_tile_wire + 16'h0003;
				cnt_periph_cell = cnt_periph_cell + 16'h0005;
				cnt_periph_wire = cnt_periph_wire + 16'h0007;
			end
		end
	end
endmodule : osc_ring_model
`default_nettype wire

// ---- dv/debug_status_register_bank_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dbg_consts.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("BAD %0t got %h exp %h", $time, (a), (e)); end end

module debug_status_register_bank_tb_top;
	logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat, entry_pc = 0, entry_sp = 0, entry_data = 0;
	logic        pready, pslverr, rerr, debug_mode = 0, dbg_entry = 0, osc_run = 0;
	logic [10:0] entry_status = 0;
	logic [2:0]  entry_cause = 0, cfg_scratch_idx = 0, pc_thread = 0;
	logic [7:0]  entry_thread = 0, core_sel_thread, thread_stop;
	logic [3:0]  entry_unit_hits = 0, ibreak_hit;
	logic        cfg_scratch_wr = 0, pc_valid = 0, ibreak_irq;
	logic [31:0] cfg_scratch_wdata = 0, cfg_scratch_rdata, pc = 0, w, e_data;
	logic [31:0] e_pc, addr[4], scr[8];
	logic [4:0]  core_sel_reg;
	logic [15:0] cnt[4];
	logic [15:0] osc_out[4];
	int          error_cnt = 0, checks = 0;

	always #5 clk_sys = ~clk_sys;

	osc_ring_model i_osc
	(
		.run             (osc_run),
		.cnt_tile_cell   (osc_out[0]),
		.cnt_tile_wire   (osc_out[1]),
		.cnt_periph_cell (osc_out[2]),
		.cnt_periph_wire (osc_out[3])
	);

	debug_status_regs #(.RAM_SIZE_BYTES(32'h00012347)) i_dut
	(
		.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .debug_mode(debug_mode),
		.osc_tile_cell(osc_out[0]), .osc_tile_wire(osc_out[1]),
		.osc_periph_cell(osc_out[2]), .osc_periph_wire(osc_out[3]),
		.dbg_entry(dbg_entry), .entry_status(entry_status), .entry_pc(entry_pc),
		.entry_sp(entry_sp), .entry_cause(entry_cause), .entry_thread(entry_thread),
		.entry_unit_hits(entry_unit_hits), .entry_data(entry_data),
		.cfg_scratch_wr(cfg_scratch_wr), .cfg_scratch_idx(cfg_scratch_idx),
		.cfg_scratch_wdata(cfg_scratch_wdata), .cfg_scratch_rdata(cfg_scratch_rdata),
		.core_sel_thread(core_sel_thread), .core_sel_reg(core_sel_reg),
		.thread_stop(thread_stop), .pc(pc), .pc_valid(pc_valid),
		.pc_thread(pc_thread), .ibreak_hit(ibreak_hit), .ibreak_irq(ibreak_irq)
	);

	// ****
	// Bus and stimulus tasks
	// ****
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, {2'b00, i, 2'b00}, d);
	endtask : wr

	task automatic rd(input logic [7:0] i);
		apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
	endtask : rd

	// Lowest unit wins; host and call report unit 0 and host thread 0
	function automatic logic [31:0] cause_word(logic [2:0] c, logic [7:0] t, logic [3:0] h);
		logic [1:0] u;
		u = 2'd0;
		for (int k = 3; k >= 0; k--)
			if (h[k])
				u = k[1:0];
		if (c < 3'd3)
			u = 2'd0;
		return {14'h0, u, (c == 3'd1) ? 8'h00 : t, 5'h00, c};
	endfunction : cause_word

	task automatic pc_pulse(input logic [31:0] p, input logic [2:0] t, input logic [3:0] eh);
		@(posedge clk_sys);
		pc <= p;
		pc_thread <= t;
		pc_valid <= 1'b1;
		@(posedge clk_sys);
		pc_valid <= 1'b0;
		#1;
		`CHK(ibreak_hit, eh)
		`CHK(ibreak_irq, |eh)
	endtask : pc_pulse

	task automatic stop_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	initial
	begin
		#200000;
		error_cnt++;
		stop_test();
	end

	// ****
	// Scenarios
	// ****
	initial
	begin
		void'($urandom(32'h1e8ae5aa));
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rd(`IDX_IRQ_CAUSE); `CHK(rdat, 32'h0)
		rd(`IDX_RAM_SIZE); `CHK(rdat, 32'h00012344)
		`CHK(rerr, 1'b0)
		osc_run <= 1'b1;
		repeat (30) @(posedge clk_sys);
		osc_run <= 1'b0;
		// Counts are only coherent once the oscillators have rested
		repeat (12) @(posedge clk_sys);
		for (int i = 0; i < 4; i++) cnt[i] = osc_out[i];
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h07 + i[7:0]); `CHK(rdat, {16'h0, cnt[i]})
		end
		@(posedge clk_sys) reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h07 + i[7:0]); `CHK(rdat, {16'h0, cnt[i]})
		end
		apb(1'b0, 12'h02c, 32'h0); `CHK(rerr, 1'b1)
		apb(1'b0, 12'h041, 32'h0); `CHK(rerr, 1'b1)
		e_data = 32'h0;
		for (int c = 1; c <= 5; c++)
		begin
			@(posedge clk_sys);
			dbg_entry <= 1'b1;
			entry_cause <= c[2:0];
			entry_status <= 11'($urandom);
			entry_pc <= $urandom;
			entry_sp <= $urandom;
			entry_thread <= 8'($urandom);
			entry_unit_hits <= (c == 3) ? 4'b1010 : 4'($urandom_range(1, 15));
			entry_data <= $urandom;
			@(posedge clk_sys);
			dbg_entry <= 1'b0;
			if (c >= 4)
				e_data = entry_data;
			rd(`IDX_SAVED_STATUS); `CHK(rdat, {21'h0, entry_status & 11'h7df})
			rd(`IDX_SAVED_PC); `CHK(rdat, entry_pc)
			rd(`IDX_SAVED_SP); `CHK(rdat, entry_sp)
			rd(`IDX_IRQ_CAUSE); `CHK(rdat, cause_word(c[2:0], entry_thread, entry_unit_hits))
			rd(`IDX_IRQ_INFO); `CHK(rdat, e_data)
		end
		e_pc = entry_pc;
		wr(`IDX_SAVED_PC, ~e_pc);
		rd(`IDX_SAVED_PC); `CHK(rdat, e_pc)
		wr(`IDX_STOP_MASK, 32'h000000ff);
		@(posedge clk_sys);
		`CHK(thread_stop, 8'h00)
		debug_mode <= 1'b1;
		w = $urandom;
		wr(`IDX_SAVED_STATUS, w);
		rd(`IDX_SAVED_STATUS); `CHK(rdat, {21'h0, (entry_status & 11'h100) | (w[10:0] & 11'h6df)})
		w = $urandom;
		wr(`IDX_SAVED_SP, w);
		rd(`IDX_SAVED_SP); `CHK(rdat, w)
		w = $urandom;
		wr(`IDX_READ_THREAD, w);
		rd(`IDX_READ_THREAD); `CHK(rdat, {24'h0, w[7:0]})
		`CHK(core_sel_thread, w[7:0])
		wr(`IDX_READ_REGNUM, 32'hffffffff);
		rd(`IDX_READ_REGNUM); `CHK(rdat, 32'h1f)
		`CHK(core_sel_reg, 5'h1f)
		w = $urandom;
		wr(`IDX_STOP_MASK, w);
		@(posedge clk_sys);
		`CHK(thread_stop, w[7:0])
		for (int i = 0; i < 8; i++)
		begin
			scr[i] = $urandom;
			wr(8'h20 + i[7:0], scr[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_sys) cfg_scratch_idx <= i[2:0];
			repeat (2) @(posedge clk_sys);
			`CHK(cfg_scratch_rdata, scr[i])
			w = $urandom;
			cfg_scratch_wr <= 1'b1;
			cfg_scratch_wdata <= w;
			@(posedge clk_sys) cfg_scratch_wr <= 1'b0;
			rd(8'h20 + i[7:0]); `CHK(rdat, w)
		end
		wr(8'h40, 32'hffffffff);
		rd(8'h40); `CHK(rdat, 32'h00ff0003)
		for (int u = 0; u < 4; u++)
		begin
			addr[u] = $urandom & 32'hfffffff0;
			wr(8'h30 + u[7:0], addr[u]);
			wr(8'h40 + u[7:0], 32'h00ff0001);
			pc_pulse(addr[u], 3'($urandom), 4'b0001 << u);
			pc_pulse(addr[u] + 32'h4, 3'd0, 4'b0000);
		end
		wr(8'h40, 32'h00010003);
		pc_pulse(addr[0] + 32'h8, 3'd0, 4'b0001);
		pc_pulse(addr[0] + 32'h8, 3'd1, 4'b0000);
		pc_pulse(addr[0], 3'd0, 4'b0000);
		stop_test();
	end
endmodule : debug_status_register_bank_tb_top
`undef CHK
`default_nettype wire
